// >>> logic/phc_top.sv
// Position hold supervisor with register file and hold state machine.
// Function
// [RL1] Enter hold at zero throttle after stop when enable set.
// [RL2] Brake type two also enables position hold.
// [RL3] Read-only engaged state reads one when holding, else zero.
// [RL4] Proportional gain, raw 41 to 2048, default ten percent.
// [RL5] Derivative gain, raw 0 to 8192, default fifteen percent.
// [RL6] Zero speed threshold 5 to 300 rpm, default 30.
// [RL7] Zero speed declared after qualify time below threshold.
// [RL8] Direction reversal through zero enters hold at once.
// [RL9] Other stops ramp to zero at entry rate, then hold.
// [RL10] Settling time in hold before brake set command.
// [RL11] Timeout plus settling time releases hold into restraint.
// [RL12] Timeout of zero disables release; hold stays engaged.
// [RL13] Interlock activation restarts the timeout timer.
// [RL14] Nonzero throttle leaves hold and clears engaged state.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module phc_top
	import phc_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	// Clock, reset and enable.
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	// Register port.
	input  wire logic        [15:0] reg_addr,
	input  wire logic        [15:0] reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic             [15:0] reg_rdata,
	// Motion feedback from same-clock logic.
	input  wire logic signed [15:0] motor_speed,
	input  wire logic signed [15:0] ramp_speed,
	input  wire logic signed [15:0] rotor_position,
	input  wire logic               throttle_active,
	// Interlock switch pin.
	input  wire logic               interlock_pin,
	// Outputs to motor control.
	output logic                    hold_engaged,
	output logic                    brake_set,
	output logic                    restraint_mode,
	output logic signed [15:0]      speed_request,
	output logic signed [15:0]      hold_torque
);

	logic [15:0] zero_speed_limit;
	logic [15:0] zero_speed_qualify_time;
	logic [15:0] hold_settling_time;
	logic [15:0] hold_entry_rate;
	logic [15:0] hold_derivative_gain;
	logic [15:0] hold_proportional_gain;
	logic [15:0] hold_function_enable;
	logic [15:0] hold_timeout_time;
	logic [15:0] brake_type_select;
	logic [15:0] parameter_change_fault;

	phc_state_t state;
	logic [31:0] tick_cnt;
	logic        tick;
	logic        il_s1;
	logic        il_s2;
	logic        il_d;
	logic        il_rise;
	logic [15:0] below_cnt;
	logic        zero_speed;
	logic        last_dir;
	logic        reversal;
	logic [15:0] hold_cnt;
	logic [15:0] timeout_cnt;
	logic        hold_allowed;
	logic        run_loop;
	logic [15:0] abs_speed;

	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		abs16 = v[15] ? 16'(-v) : 16'(v);
	endfunction
	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction
	function automatic logic [17:0] long_ticks(input logic [15:0] v);
		long_ticks = 18'(v) << LONG_TIME_SHIFT;
	endfunction

	// Control tick divider; all times count in ticks.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= 32'h0;
			tick     <= 1'b0;
		end else if (clk_en) begin
			if (tick_cnt >= 32'(TICK_LEN - 1)) begin
				tick_cnt <= 32'h0;
				tick     <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 32'h1;
				tick     <= 1'b0;
			end
		end
	end

	// The interlock is a pin, so it is synchronised before use.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			il_s1 <= 1'b0;
			il_s2 <= 1'b0;
			il_d  <= 1'b0;
		end else if (clk_en) begin
			il_s1 <= interlock_pin;
			il_s2 <= il_s1;
			il_d  <= il_s2;
		end
	end
	assign il_rise = il_s2 && !il_d;

	// Out-of-range writes are refused and flag a parameter change fault.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			zero_speed_limit        <= RST_ZERO_SPEED_LIMIT;
			zero_speed_qualify_time <= RST_QUALIFY_TIME;
			hold_settling_time      <= RST_SETTLING_TIME;
			hold_entry_rate         <= RST_ENTRY_RATE;
			hold_derivative_gain    <= RST_DERIVATIVE_GAIN;
			hold_proportional_gain  <= RST_PROPORTIONAL_GAIN;
			hold_function_enable    <= 16'h0000; // see [RL1]
			hold_timeout_time       <= RST_TIMEOUT_TIME;
			brake_type_select       <= 16'h0000;
			parameter_change_fault  <= 16'h0000;
		end else if (clk_en && reg_wr) begin
			unique case (reg_addr)
			REG_ZERO_SPEED_LIMIT: begin
				if (in_range(reg_wdata, MIN_ZERO_SPEED_LIMIT,
					MAX_ZERO_SPEED_LIMIT))
					zero_speed_limit <= reg_wdata; // see [RL6]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_ZERO_SPEED_QUALIFY: begin
				if (reg_wdata <= MAX_QUALIFY_TIME)
					zero_speed_qualify_time <= reg_wdata; // see [RL7]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_HOLD_SETTLING_TIME: begin
				if (reg_wdata <= MAX_SETTLING_TIME)
					hold_settling_time <= reg_wdata; // see [RL10]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_HOLD_ENTRY_RATE: begin
				if (in_range(reg_wdata, MIN_ENTRY_RATE, MAX_ENTRY_RATE))
					hold_entry_rate <= reg_wdata; // see [RL9]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_HOLD_DERIVATIVE_GAIN: begin
				if (reg_wdata <= MAX_DERIVATIVE_GAIN)
					hold_derivative_gain <= reg_wdata; // see [RL5]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_HOLD_PROPORTIONAL_GAIN: begin
				if (in_range(reg_wdata, MIN_PROPORTIONAL_GAIN,
					MAX_PROPORTIONAL_GAIN))
					hold_proportional_gain <= reg_wdata; // see [RL4]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_HOLD_FUNCTION_ENABLE: begin
				hold_function_enable <= {15'h0, reg_wdata[0]};
				parameter_change_fault <= 16'h0001;
			end
			REG_HOLD_TIMEOUT_TIME: begin
				if (reg_wdata <= MAX_TIMEOUT_TIME)
					hold_timeout_time <= reg_wdata; // see [RL11]
				else
					parameter_change_fault <= 16'h0001;
			end
			REG_BRAKE_TYPE_SELECT: brake_type_select <= reg_wdata;
			REG_PARAM_FAULT: parameter_change_fault <= 16'h0000;
			default: ;
			endcase
		end
	end

	// Read data appear in the cycle after the read strobe only.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				unique case (reg_addr)
				REG_ZERO_SPEED_LIMIT:       reg_rdata <= zero_speed_limit;
				REG_ZERO_SPEED_QUALIFY:     reg_rdata <= zero_speed_qualify_time;
				REG_HOLD_SETTLING_TIME:     reg_rdata <= hold_settling_time;
				REG_HOLD_ENTRY_RATE:        reg_rdata <= hold_entry_rate;
				REG_HOLD_DERIVATIVE_GAIN:   reg_rdata <= hold_derivative_gain;
				REG_HOLD_PROPORTIONAL_GAIN: reg_rdata <= hold_proportional_gain;
				REG_HOLD_FUNCTION_ENABLE:   reg_rdata <= hold_function_enable;
				REG_HOLD_ENGAGED_STATE:
					reg_rdata <= hold_engaged ? ENGAGED_ON : ENGAGED_OFF; // see [RL3]
				REG_HOLD_TIMEOUT_TIME:      reg_rdata <= hold_timeout_time;
				REG_BRAKE_TYPE_SELECT:      reg_rdata <= brake_type_select;
				REG_PARAM_FAULT:            reg_rdata <= parameter_change_fault;
				default:                    reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	assign abs_speed = abs16(motor_speed);
	assign hold_allowed = hold_function_enable[0]
		|| (brake_type_select == BRAKE_TYPE_HOLD); // see [RL1] [RL2]

	// Zero speed needs the speed held below threshold for the qualify time.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			below_cnt  <= 16'h0;
			zero_speed <= 1'b0;
		end else if (clk_en) begin
			if (abs_speed >= zero_speed_limit) begin
				below_cnt  <= 16'h0;
				zero_speed <= 1'b0;
			end else if (tick) begin
				if (below_cnt >= zero_speed_qualify_time)
					zero_speed <= 1'b1; // see [RL6] [RL7]
				else
					below_cnt <= below_cnt + 16'h1;
			end
		end
	end

	// A sign change of speed while coasting marks a reversal stop.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			last_dir <= 1'b0;
			reversal <= 1'b0;
		end else if (clk_en) begin
			if (motor_speed != 16'sh0000) begin
				last_dir <= motor_speed[15];
				if (motor_speed[15] != last_dir && !throttle_active)
					reversal <= 1'b1; // see [RL8]
			end
			if (state != ST_DRIVE || throttle_active)
				reversal <= 1'b0;
		end
	end

	// Hold state machine.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state          <= ST_DRIVE;
			hold_engaged   <= 1'b0;
			brake_set      <= 1'b0;
			restraint_mode <= 1'b0;
			speed_request  <= 16'sh0000;
			hold_cnt       <= 16'h0;
			timeout_cnt    <= 16'h0;
		end else if (clk_en) begin
			unique case (state)
			ST_DRIVE: begin
				speed_request <= ramp_speed;
				if (!throttle_active && hold_allowed) begin
					if (reversal && abs_speed < zero_speed_limit) begin
						state        <= ST_HOLD; // see [RL8]
						hold_engaged <= 1'b1;
					end else if (ramp_speed == 16'sh0000) begin
						state <= ST_ENTRY; // see [RL9]
					end
				end
			end
			ST_ENTRY: begin
				if (throttle_active) begin
					state <= ST_DRIVE;
				end else if (tick) begin
					// Step the request toward zero by the entry rate.
					if (abs16(speed_request) <= hold_entry_rate)
						speed_request <= 16'sh0000;
					else if (speed_request[15])
						speed_request <= speed_request + hold_entry_rate;
					else
						speed_request <= speed_request - hold_entry_rate;
				end
				if (!throttle_active && zero_speed
					&& speed_request == 16'sh0000) begin
					state        <= ST_HOLD; // see [RL1] [RL9]
					hold_engaged <= 1'b1;
				end
			end
			ST_HOLD, ST_BRAKE: begin
				speed_request <= 16'sh0000;
				if (tick && hold_cnt != 16'hFFFF)
					hold_cnt <= hold_cnt + 16'h1;
				if (il_rise)
					timeout_cnt <= 16'h0; // see [RL13]
				else if (tick && timeout_cnt != 16'hFFFF)
					timeout_cnt <= timeout_cnt + 16'h1;
				if (18'(hold_cnt) >= long_ticks(hold_settling_time)) begin
					state     <= ST_BRAKE;
					brake_set <= 1'b1; // see [RL10]
				end
				// Zero timeout never releases the hold.
				if (hold_timeout_time != 16'h0 && !il_rise
					&& 18'(timeout_cnt) >= long_ticks(hold_timeout_time)
					+ long_ticks(hold_settling_time)) begin
					state          <= ST_RESTR; // see [RL11] [RL12]
					hold_engaged   <= 1'b0;
					restraint_mode <= 1'b1;
				end
				if (throttle_active) begin
					state          <= ST_DRIVE; // see [RL14]
					hold_engaged   <= 1'b0;
					brake_set      <= 1'b0;
					restraint_mode <= 1'b0;
					hold_cnt       <= 16'h0;
					timeout_cnt    <= 16'h0;
				end
			end
			ST_RESTR: begin
				speed_request <= 16'sh0000;
				if (throttle_active) begin
					state          <= ST_DRIVE;
					brake_set      <= 1'b0;
					restraint_mode <= 1'b0;
					hold_cnt       <= 16'h0;
					timeout_cnt    <= 16'h0;
				end
			end
			default: state <= ST_DRIVE;
			endcase
		end
	end

	assign run_loop = hold_engaged;

	phc_pd_loop u_loop (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.tick     (tick),
		.run      (run_loop),
		.kp       (hold_proportional_gain),
		.kd       (hold_derivative_gain),
		.position (rotor_position),
		.torque   (hold_torque)
	);

endmodule

// >>> logic/phc_pkg.sv
// Package of constants and types for the position hold controller.
package phc_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [15:0] REG_ZERO_SPEED_LIMIT      = 16'h30F2;
	localparam logic [15:0] REG_ZERO_SPEED_QUALIFY    = 16'h30F3;
	localparam logic [15:0] REG_HOLD_SETTLING_TIME    = 16'h3783;
	localparam logic [15:0] REG_HOLD_ENTRY_RATE       = 16'h3786;
	localparam logic [15:0] REG_HOLD_DERIVATIVE_GAIN  = 16'h378C;
	localparam logic [15:0] REG_HOLD_PROPORTIONAL_GAIN = 16'h378D;
	localparam logic [15:0] REG_HOLD_FUNCTION_ENABLE  = 16'h3793;
	localparam logic [15:0] REG_HOLD_ENGAGED_STATE    = 16'h3794;
	localparam logic [15:0] REG_HOLD_TIMEOUT_TIME     = 16'h3795;
	localparam logic [15:0] REG_BRAKE_TYPE_SELECT     = 16'h37A0;
	localparam logic [15:0] REG_PARAM_FAULT           = 16'h37A1;

	// Reset values in raw units.
	localparam logic [15:0] RST_ZERO_SPEED_LIMIT = 16'h001E;
	localparam logic [15:0] RST_QUALIFY_TIME     = 16'h0004;
	localparam logic [15:0] RST_SETTLING_TIME    = 16'h005E;
	localparam logic [15:0] RST_ENTRY_RATE       = 16'h01F4;
	localparam logic [15:0] RST_DERIVATIVE_GAIN  = 16'h04CD;
	localparam logic [15:0] RST_PROPORTIONAL_GAIN = 16'h00CD;
	localparam logic [15:0] RST_TIMEOUT_TIME     = 16'h0000;

	// Legal raw ranges.
	localparam logic [15:0] MIN_ZERO_SPEED_LIMIT = 16'h0005;
	localparam logic [15:0] MAX_ZERO_SPEED_LIMIT = 16'h012C;
	localparam logic [15:0] MAX_QUALIFY_TIME     = 16'h003C;
	localparam logic [15:0] MAX_SETTLING_TIME    = 16'h009C;
	localparam logic [15:0] MIN_ENTRY_RATE       = 16'h0032;
	localparam logic [15:0] MAX_ENTRY_RATE       = 16'h03E8;
	localparam logic [15:0] MAX_DERIVATIVE_GAIN  = 16'h2000;
	localparam logic [15:0] MIN_PROPORTIONAL_GAIN = 16'h0029;
	localparam logic [15:0] MAX_PROPORTIONAL_GAIN = 16'h0800;
	localparam logic [15:0] MAX_TIMEOUT_TIME     = 16'h0271;

	localparam logic [15:0] BRAKE_TYPE_HOLD = 16'h0002;
	localparam logic [15:0] ENGAGED_ON      = 16'h0001;
	localparam logic [15:0] ENGAGED_OFF     = 16'h0000;

	// The qualify time counts in control ticks of 8 ms.
	localparam int TICK_MS = 8;
	localparam int CLK_HZ  = 20000000;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int GAIN_SHIFT  = 11;
	// Settling and timeout count in 32 ms units of four ticks, so that
	// their raw ranges reach 5 s and 20 s.
	localparam int LONG_TIME_SHIFT = 2;

	// Register bus request.
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} phc_bus_req_t;

	// Motion inputs sampled each tick.
	typedef struct packed {
		logic signed [15:0] speed;
		logic signed [15:0] ramp_speed;
		logic signed [15:0] position;
		logic               throttle;
		logic               interlock;
	} phc_motion_t;

	typedef enum logic [4:0] {
		ST_DRIVE  = 5'h01,
		ST_ENTRY  = 5'h02,
		ST_HOLD   = 5'h04,
		ST_BRAKE  = 5'h08,
		ST_RESTR  = 5'h10
	} phc_state_t;

endpackage

// >>> logic/phc_pd_loop.sv
// Proportional and derivative position regulator used while holding.
`timescale 1ns/1ps
module phc_pd_loop
	import phc_pkg::*;
(
	// Clock and control.
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	input  wire logic               tick,
	input  wire logic               run,
	// Gains and measurement.
	input  wire logic        [15:0] kp,
	input  wire logic        [15:0] kd,
	input  wire logic signed [15:0] position,
	// Torque command.
	output logic signed [15:0]      torque
);

	logic signed [15:0] anchor;
	logic signed [15:0] last_err;
	logic signed [15:0] err;
	logic signed [16:0] derr;
	logic signed [33:0] sum;

	function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
		if (v > 34'sd32767)
			sat16 = 16'sh7FFF;
		else if (v < -34'sd32768)
			sat16 = 16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	assign err  = anchor - position;
	assign derr = 17'(err) - 17'(last_err);
	// Higher gains give a stiffer and more damped response.
	assign sum  = (34'(err) * $signed({1'b0, kp})
		+ 34'(derr) * $signed({1'b0, kd})) >>> GAIN_SHIFT;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			anchor   <= 16'sh0000;
			last_err <= 16'sh0000;
			torque   <= 16'sh0000;
		end else if (clk_en) begin
			if (!run) begin
				// The position at entry becomes the hold target.
				anchor   <= position;
				last_err <= 16'sh0000;
				torque   <= 16'sh0000;
			end else if (tick) begin
				last_err <= err;
				torque   <= sat16(sum); // see [RL4] [RL5]
			end
		end
	end

endmodule

// >>> tb/phc_top_asserts.sv
// Port checker for the position hold controller, bound to its top.
`timescale 1ns/1ps
module phc_top_chk
	import phc_pkg::*;
#(
	parameter int TICK_LEN = 4
)
(
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	// Register port.
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Hold status.
	input wire logic        throttle_active,
	input wire logic        hold_engaged,
	input wire logic        brake_set,
	input wire logic        restraint_mode,
	input wire logic [15:0] hold_torque
);
	logic en_q;
	logic bt_q;

	// Shadows of the two settings that permit a hold.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 1'b0;
		end else if (clk_en && reg_wr && reg_addr == REG_HOLD_FUNCTION_ENABLE) begin
			en_q <= reg_wdata[0];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bt_q <= 1'b0;
		end else if (clk_en && reg_wr && reg_addr == REG_BRAKE_TYPE_SELECT) begin
			bt_q <= (reg_wdata == BRAKE_TYPE_HOLD);
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence eng_rd_s;
		reg_rd && reg_addr == REG_HOLD_ENGAGED_STATE ##1 $stable(hold_engaged);
	endsequence

	sequence hold_rise_s;
		$rose(hold_engaged);
	endsequence

	eng_read_a: assert property (
		$stable(hold_engaged) ##0 eng_rd_s
		|-> reg_rdata == {15'h0000, hold_engaged})
		else $error("engaged state read differs from output");
	rdata_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside read cycle");
	throttle_exit_a: assert property (
		throttle_active && clk_en
		|=> !hold_engaged && !brake_set && !restraint_mode)
		else $error("throttle did not clear hold");
	torque_idle_a: assert property (
		!hold_engaged [*2] |-> hold_torque == 16'h0000)
		else $error("torque present outside hold");
	brake_hold_a: assert property (
		$rose(brake_set) |-> hold_engaged)
		else $error("brake set without hold");
	restr_brake_a: assert property (
		$rose(restraint_mode) |-> $past(brake_set))
		else $error("restraint before settling done");
	hold_enable_a: assert property (
		hold_rise_s |-> en_q || bt_q)
		else $error("hold entered while disabled");
	hold_throttle_a: assert property (
		hold_rise_s |-> !$past(throttle_active))
		else $error("hold entered under throttle");
endmodule

bind phc_top phc_top_chk #(.TICK_LEN(TICK_LEN)) phc_top_chk_i (
	.mclk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .throttle_active, .hold_engaged, .brake_set,
	.restraint_mode, .hold_torque
);

// >>> tb/phc_motor_model.sv
// Behavioural traction motor with brake and position feedback.
`timescale 1ns/1ps
module phc_motor_model
	import phc_pkg::*;
(
	// Clock and reset.
	input  wire logic               mclk,
	input  wire logic               reset_n,
	// Commands.
	input  wire logic               throttle_active,
	input  wire logic signed [15:0] drive_speed,
	input  wire logic signed [15:0] speed_request,
	input  wire logic               brake_set,
	// Feedback.
	output logic signed [15:0]      motor_speed,
	output logic signed [15:0]      rotor_position
);
	// The rotor closes a quarter of the gap each cycle, so a stop takes time.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			motor_speed <= 16'sh0000;
		end else if (brake_set) begin
			motor_speed <= 16'sh0000;
		end else if (throttle_active) begin
			motor_speed <= drive_speed;
		end else begin
			motor_speed <= motor_speed - ((motor_speed - speed_request) >>> 2);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rotor_position <= 16'sh0000;
		end else begin
			rotor_position <= rotor_position + (motor_speed >>> 3);
		end
	end
endmodule

// >>> tb/phc_top_tb.sv
// Self-checking bench for the position hold controller.
`timescale 1ns/1ps
module phc_top_tb
	import phc_pkg::*;
;
	localparam int TL = 4;
	logic               mclk = 1'b0;
	logic               reset_n = 1'b0;
	logic               clk_en = 1'b1;
	logic        [15:0] reg_addr = 16'h0000;
	logic        [15:0] reg_wdata = 16'h0000;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic        [15:0] reg_rdata;
	logic signed [15:0] motor_speed;
	logic signed [15:0] ramp_speed = 16'sh0000;
	logic signed [15:0] drive_speed = 16'sh0064;
	logic signed [15:0] rotor_position;
	logic signed [15:0] speed_request;
	logic signed [15:0] hold_torque;
	logic               throttle_active = 1'b1;
	logic               interlock_pin = 1'b0;
	logic               hold_engaged;
	logic               brake_set;
	logic               restraint_mode;
	logic         [2:0] outs;
	int                 bad_count = 0;
	int                 n_tests = 0;
	int                 cyc = 0;
	int                 n;

	assign outs = {restraint_mode, brake_set, hold_engaged};

	phc_top #(.TICK_LEN(TL)) phc_top_i (
		.mclk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .motor_speed, .ramp_speed, .rotor_position,
		.throttle_active, .interlock_pin, .hold_engaged, .brake_set,
		.restraint_mode, .speed_request, .hold_torque
	);

	phc_motor_model phc_motor_model_i (
		.mclk, .reset_n, .throttle_active, .drive_speed, .speed_request,
		.brake_set, .motor_speed, .rotor_position
	);

	always #25 mclk = ~mclk;

	// Longest test path is a few thousand cycles; the ceiling leaves slack.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(reg_rdata, e);
	endtask

	task automatic wait_for(input int b, input int lim);
		n = 0;
		while (outs[b] !== 1'b1 && n < lim) begin
			@(negedge mclk);
			n++;
		end
	endtask

	task automatic go(input logic t);
		@(posedge mclk);
		throttle_active <= t;
		ramp_speed <= t ? drive_speed : 16'sh0000;
		repeat (20) @(posedge mclk);
	endtask

	task automatic t_defaults();
		logic [15:0] ra [9];
		logic [15:0] rv [9];
		ra = '{REG_ZERO_SPEED_LIMIT, REG_ZERO_SPEED_QUALIFY,
			REG_HOLD_SETTLING_TIME, REG_HOLD_ENTRY_RATE,
			REG_HOLD_DERIVATIVE_GAIN, REG_HOLD_PROPORTIONAL_GAIN,
			REG_HOLD_FUNCTION_ENABLE, REG_HOLD_ENGAGED_STATE,
			REG_HOLD_TIMEOUT_TIME};
		rv = '{16'h001E, 16'h0004, 16'h005E, 16'h01F4, 16'h04CD,
			16'h00CD, 16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 9; i++) begin
			rchk(ra[i], rv[i]);
		end
		rchk(16'h1234, 16'h0000);
		wr(REG_HOLD_ENGAGED_STATE, 16'h0001);
		rchk(REG_HOLD_ENGAGED_STATE, ENGAGED_OFF);
		wr(REG_HOLD_PROPORTIONAL_GAIN, 16'h0028);
		rchk(REG_HOLD_PROPORTIONAL_GAIN, 16'h00CD);
		rchk(REG_PARAM_FAULT, 16'h0001);
		wr(REG_HOLD_PROPORTIONAL_GAIN, 16'h0800);
		rchk(REG_HOLD_PROPORTIONAL_GAIN, 16'h0800);
		wr(REG_HOLD_DERIVATIVE_GAIN, 16'h2001);
		rchk(REG_HOLD_DERIVATIVE_GAIN, 16'h04CD);
		wr(REG_ZERO_SPEED_LIMIT, 16'h0004);
		rchk(REG_ZERO_SPEED_LIMIT, 16'h001E);
		wr(REG_HOLD_SETTLING_TIME, 16'h0003);
		rchk(REG_HOLD_SETTLING_TIME, 16'h0003);
		$display("test defaults done");
	endtask

	task automatic t_disabled();
		go(1'b1);
		go(1'b0);
		wait_for(0, 200);
		chk({15'h0000, hold_engaged}, 16'h0000);
		$display("test disabled done");
	endtask

	task automatic t_hold();
		wr(REG_HOLD_FUNCTION_ENABLE, 16'h0001);
		go(1'b1);
		go(1'b0);
		wait_for(0, 400);
		chk({15'h0000, hold_engaged}, 16'h0001);
		rchk(REG_HOLD_ENGAGED_STATE, ENGAGED_ON);
		wait_for(1, 200);
		// Three raw units of 32 ms are twelve ticks of four cycles.
		chk({15'h0000, n >= 40 && n <= 50}, 16'h0001);
		repeat (150) @(posedge mclk);
		@(negedge mclk);
		chk({14'h0000, restraint_mode, hold_engaged}, 16'h0001);
		go(1'b1);
		chk({14'h0000, brake_set, hold_engaged}, 16'h0000);
		chk(speed_request, drive_speed);
		rchk(REG_HOLD_ENGAGED_STATE, ENGAGED_OFF);
		$display("test hold done");
	endtask

	// A small reverse request lets the rotor coast through zero slowly.
	task automatic t_reversal();
		@(posedge mclk);
		throttle_active <= 1'b0;
		ramp_speed <= -16'sh0014;
		wait_for(0, 100);
		chk({15'h0000, hold_engaged}, 16'h0001);
		repeat (30) @(negedge mclk);
		chk(speed_request, 16'h0000);
		chk({15'h0000, hold_torque > 16'sh0000}, 16'h0001);
		go(1'b1);
		$display("test reversal done");
	endtask

	task automatic t_timeout();
		wr(REG_HOLD_TIMEOUT_TIME, 16'h0006);
		go(1'b0);
		wait_for(0, 400);
		wait_for(2, 200);
		chk({15'h0000, n >= 138 && n <= 150}, 16'h0001);
		go(1'b1);
		go(1'b0);
		wait_for(0, 400);
		repeat (16) @(posedge mclk);
		interlock_pin <= 1'b1;
		repeat (3) @(posedge mclk);
		interlock_pin <= 1'b0;
		wait_for(2, 200);
		chk({15'h0000, n >= 138 && n <= 152}, 16'h0001);
		go(1'b1);
		$display("test timeout done");
	endtask

	task automatic t_brake_type();
		wr(REG_HOLD_FUNCTION_ENABLE, 16'h0000);
		wr(REG_HOLD_TIMEOUT_TIME, 16'h0000);
		wr(REG_BRAKE_TYPE_SELECT, BRAKE_TYPE_HOLD);
		go(1'b0);
		wait_for(0, 400);
		chk({15'h0000, hold_engaged}, 16'h0001);
		go(1'b1);
		$display("test brake type done");
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		t_defaults();
		t_disabled();
		t_hold();
		t_reversal();
		t_timeout();
		t_brake_type();
		report_and_stop();
	end
endmodule
